// File: rtl/pin_mux_cfg.svh
// Constants for the serial audio data pin multiplexer.
// Contract
// - Output pin assigned to transmit drives from reversed-index transmit shift register (pad 0 from register 5).
// - Input pin assigned to receive feeds same-index receive shift register.
// - In general-purpose use each port line is input, output or disconnected.
// - After reset every pin is disconnected, neither driving nor sampling.
// - Secondary enable moves outputs 2-5 and inputs 2-3 to secondary interface.
// - Secondary general-purpose enable makes first lines 8-11 second lines 8-11.
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define PIN_COUNT      6
`define TX_CHANNELS    6
`define RX_CHANNELS    4
`define SEC_CHANNELS   4
`define FIRST_LINE_LOW 6
`define SEC_FIRST_PIN  2
`define SEC_RX_LOW     2
`define MODE_WIDTH     3
`endif

// File: rtl/pin_mux_pkg.sv
// Types for the serial audio data pin multiplexer.
`include "pin_mux_cfg.svh"
package pin_mux_pkg;
	typedef enum logic [`MODE_WIDTH-1:0] {
		PIN_OFF,
		PIN_GPIO_IN,
		PIN_GPIO_OUT,
		PIN_TX,
		PIN_RX
	} pin_mode_t;

	typedef struct packed {
		logic                         secondary_en;
		logic                         secondary_gpio_en;
		pin_mode_t [`PIN_COUNT-1:0]   mode;
	} mux_ctrl_t;

	typedef struct packed {
		logic [`PIN_COUNT-1:0] level;
		logic [`PIN_COUNT-1:0] oe_n;
	} pad_drive_t;
endpackage

// File: rtl/audio_serial_data_pin_mux.sv
// Pin function multiplexer for the serial audio data pins.
`include "pin_mux_cfg.svh"
module audio_serial_data_pin_mux
	import pin_mux_pkg::*;
(
	input  wire logic                       clock,          // 100 MHz clock
	input  wire logic                       sys_rst,        // Sync reset
	input  wire mux_ctrl_t                  ctrl,           // Pin selection
	input  wire logic [`TX_CHANNELS-1:0]    primary_tx,     // Primary tx bits
	input  wire logic [`SEC_CHANNELS-1:0]   secondary_tx,   // Secondary tx
	input  wire logic [`PIN_COUNT-1:0]      first_port_out, // Lines 6..11 out
	input  wire logic [`SEC_CHANNELS-1:0]   second_port_out,// Lines 8..11 out
	input  wire logic [`PIN_COUNT-1:0]      pad_in,         // Pad levels
	output pad_drive_t                      pad,            // Pad drive
	output logic [`RX_CHANNELS-1:0]         primary_rx,     // Primary rx bits
	output logic [`SEC_CHANNELS-1:0]        secondary_rx,   // Secondary rx
	output logic [`PIN_COUNT-1:0]           first_port_in,  // Lines 6..11 in
	output logic [`SEC_CHANNELS-1:0]        second_port_in  // Lines 8..11 in
);
	mux_ctrl_t                  ctrl_reg;
	pad_drive_t                 pad_next;
	logic [`RX_CHANNELS-1:0]    prim_rx_next;
	logic [`SEC_CHANNELS-1:0]   sec_rx_next;
	logic [`PIN_COUNT-1:0]      first_in_next;
	logic [`SEC_CHANNELS-1:0]   second_in_next;

	// Receive is only wired on the first RX_CHANNELS pins; other codes
	// on a pin fall back to disconnected so no stray function appears.
	function automatic pin_mode_t legal_mode(input int idx,
	                                         input pin_mode_t m);
		legal_mode = m;
		if (m == PIN_RX && idx >= `RX_CHANNELS) begin
			legal_mode = PIN_OFF;
		end
		if (m > PIN_RX) begin
			legal_mode = PIN_OFF;
		end
	endfunction

	// Selection is latched so reset forces every pin disconnected.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_reg <= '0;
		end else begin
			ctrl_reg <= ctrl;
		end
	end

	// Primary transmit channel of a pad; pad 0 carries channel 5.
	function automatic logic [2:0] tx_channel(input int pin);
		tx_channel = 3'(`TX_CHANNELS - 1 - pin);
	endfunction

	// Lane of the secondary port behind a shared pad.
	function automatic logic [1:0] sec_lane(input int pin);
		sec_lane = 2'(pin - `SEC_FIRST_PIN);
	endfunction

	// Secondary transmit lane of a shared pad; pad 2 carries lane 3.
	function automatic logic [1:0] sec_tx_lane(input int pin);
		sec_tx_lane = 2'(`TX_CHANNELS - 1 - pin);
	endfunction

	// True for the pads that the secondary interface may take over.
	function automatic logic sec_capable(input int pin);
		sec_capable = (pin >= `SEC_FIRST_PIN);
	endfunction

	// True for the receive pads that may move to the secondary side.
	function automatic logic sec_rx_capable(input int pin);
		sec_rx_capable = (pin >= `SEC_RX_LOW) && (pin < `RX_CHANNELS);
	endfunction

	// True when the function turns the pad driver on.
	function automatic logic mode_drives(input pin_mode_t m);
		mode_drives = (m == PIN_TX) || (m == PIN_GPIO_OUT);
	endfunction

	// True when the function listens to the pad level.
	function automatic logic mode_samples(input pin_mode_t m);
		mode_samples = (m == PIN_RX) || (m == PIN_GPIO_IN);
	endfunction

	pin_mode_t [`PIN_COUNT-1:0] eff_mode;
	logic [`PIN_COUNT-1:0]      sec_owns;
	logic [`PIN_COUNT-1:0]      sec_gpio_owns;
	logic [`PIN_COUNT-1:0]      listen;
	logic [`PIN_COUNT-1:0]      pad_seen;
	logic [`PIN_COUNT-1:0]      drive_oe_n;

	// Folded function and ownership of every pad, shared by the paths below.
	always_comb begin
		for (int p = 0; p < `PIN_COUNT; p++) begin
			eff_mode[p]      = legal_mode(p, ctrl_reg.mode[p]);
			sec_owns[p]      = ctrl_reg.secondary_en && sec_capable(p);
			sec_gpio_owns[p] = ctrl_reg.secondary_gpio_en && sec_capable(p);
			listen[p]        = mode_samples(eff_mode[p]);
		end
	end

	// A pad level reaches a function only while that function listens.
	always_comb begin
		pad_seen = pad_in & listen;
	end

	// The driver is on only for a transmit or output function.
	always_comb begin
		drive_oe_n = '1;
		for (int p = 0; p < `PIN_COUNT; p++) begin
			drive_oe_n[p] = !mode_drives(eff_mode[p]);
		end
	end

	// Pad levels; a pad whose driver is off is held low inside the block.
	always_comb begin
		pad_next.oe_n  = drive_oe_n;
		pad_next.level = '0;
		for (int p = 0; p < `PIN_COUNT; p++) begin
			unique case (eff_mode[p])
				PIN_TX: begin
					if (sec_owns[p]) begin
						pad_next.level[p] = secondary_tx[sec_tx_lane(p)];
					end else begin
						pad_next.level[p] = primary_tx[tx_channel(p)];
					end
				end
				PIN_GPIO_OUT: begin
					if (sec_gpio_owns[p]) begin
						pad_next.level[p] = second_port_out[sec_lane(p)];
					end else begin
						pad_next.level[p] = first_port_out[p];
					end
				end
				PIN_OFF, PIN_GPIO_IN, PIN_RX: begin
					pad_next.level[p] = 1'b0;
				end
				default: begin
					pad_next.level[p] = 1'b0;
				end
			endcase
		end
	end

	// Primary receive channels take their pad while no secondary lane does.
	always_comb begin
		prim_rx_next = '0;
		for (int p = 0; p < `RX_CHANNELS; p++) begin
			unique case (eff_mode[p])
				PIN_RX: begin
					if (!(sec_owns[p] && sec_rx_capable(p))) begin
						prim_rx_next[p] = pad_seen[p];
					end
				end
				default: begin
					prim_rx_next[p] = 1'b0;
				end
			endcase
		end
	end

	// Secondary receive lanes sit at the index of their channel.
	always_comb begin
		sec_rx_next = '0;
		for (int p = 0; p < `RX_CHANNELS; p++) begin
			if (eff_mode[p] == PIN_RX && sec_owns[p] && sec_rx_capable(p)) begin
				sec_rx_next[p] = pad_seen[p];
			end
		end
	end

	// General-purpose inputs follow the port that owns the pad.
	always_comb begin
		first_in_next  = '0;
		second_in_next = '0;
		for (int p = 0; p < `PIN_COUNT; p++) begin
			unique case (eff_mode[p])
				PIN_GPIO_IN: begin
					if (sec_gpio_owns[p]) begin
						second_in_next[sec_lane(p)] = pad_seen[p];
					end else begin
						first_in_next[p] = pad_seen[p];
					end
				end
				default: begin
					first_in_next[p] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pad <= '{level: '0, oe_n: '1};
		end else begin
			pad <= pad_next;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			primary_rx <= '0;
		end else begin
			primary_rx <= prim_rx_next;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			secondary_rx <= '0;
		end else begin
			secondary_rx <= sec_rx_next;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			first_port_in <= '0;
		end else begin
			first_port_in <= first_in_next;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			second_port_in <= '0;
		end else begin
			second_port_in <= second_in_next;
		end
	end
endmodule

// File: sim/codec_model.sv
// Far-side converter model that drives changing data onto the pads.
module codec_model (
	input  wire logic       clock, // Clock
	output logic      [5:0] line   // Far-side levels
);
	timeunit 1ns;
	timeprecision 1ps;
	initial line = 6'h2A;
	always @(posedge clock) line <= line + 6'h15;
endmodule

// File: sim/pin_mux_checker.sv
// Port assertions for the serial audio data pin multiplexer.
module pin_mux_checker
	import pin_mux_pkg::*;
(
	input wire logic       clock,          // Clock
	input wire logic       sys_rst,        // Reset
	input wire mux_ctrl_t  ctrl,           // Selection
	input wire logic [5:0] primary_tx,     // Tx bits
	input wire logic [3:0] secondary_tx,   // Tx bits
	input wire logic [5:0] pad_in,         // Pads
	input wire pad_drive_t pad,            // Drive
	input wire logic [3:0] primary_rx,     // Rx bits
	input wire logic [5:0] first_port_in,  // Gpio in
	input wire logic [3:0] second_port_in  // Gpio in
);
	timeunit 1ns;
	timeprecision 1ps;
	mux_ctrl_t c1, c;
	always_ff @(posedge clock) begin
		c1 <= sys_rst ? '0 : ctrl;
		c <= sys_rst ? '0 : c1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	tx_drive_a: assert property (c.mode[0] == PIN_TX |->
		!pad.oe_n[0] && pad.level[0] == $past(primary_tx[5])) else $error("tx");
	rx_feed_a: assert property (c.mode[1] == PIN_RX |->
		primary_rx[1] == $past(pad_in[1])) else $error("rx");
	gpio_in_a: assert property (c.mode[0] == PIN_GPIO_IN |->
		first_port_in[0] == $past(pad_in[0]) && pad.oe_n[0]) else $error("gin");
	reset_off_a: assert property ($fell(sys_rst) |->
		&pad.oe_n && primary_rx == 4'h0) else $error("reset");
	off_release_a: assert property (c.mode[4] == PIN_OFF |->
		pad.oe_n[4] && !first_port_in[4]) else $error("off");
	sec_tx_a: assert property (c.secondary_en && c.mode[5] == PIN_TX |->
		pad.level[5] == $past(secondary_tx[0])) else $error("sec tx");
	sec_gpio_a: assert property (c.secondary_gpio_en &&
		c.mode[2] == PIN_GPIO_IN |-> second_port_in[0] == $past(pad_in[2])
		&& !first_port_in[2]) else $error("sec gpio");
	rx_refuse_a: assert property (c.mode[5] == PIN_RX |->
		pad.oe_n[5] && !first_port_in[5]) else $error("refuse");
endmodule
bind audio_serial_data_pin_mux pin_mux_checker chk (.clock, .sys_rst, .ctrl,
	.primary_tx, .secondary_tx, .pad_in, .pad, .primary_rx, .first_port_in,
	.second_port_in);

// File: sim/audio_serial_data_pin_mux_tb.sv
// Self-checking testbench for the serial audio data pin multiplexer.
module audio_serial_data_pin_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pin_mux_pkg::*;
	logic clock = 0, sys_rst = 1;
	mux_ctrl_t ctrl = '0;
	logic [5:0] ptx = 6'h0B, fpo = 6'h15, pin, far, e, fpi;
	logic [3:0] stx = 4'h4, spo = 4'hA, prx, srx, spi;
	pad_drive_t pad;
	int bad_count = 0, checks_done = 0;
	always #5 clock = ~clock;
	// Pads released by the block show the far side's levels.
	assign pin = ~pad.oe_n & pad.level | pad.oe_n & far;
	codec_model far_end (.clock(clock), .line(far));
	audio_serial_data_pin_mux DUT (.clock(clock), .sys_rst(sys_rst),
		.ctrl(ctrl), .primary_tx(ptx), .secondary_tx(stx),
		.first_port_out(fpo), .second_port_out(spo), .pad_in(pin), .pad(pad),
		.primary_rx(prx), .secondary_rx(srx), .first_port_in(fpi),
		.second_port_in(spi));
	task check(string n, logic [5:0] x, logic [5:0] g);
		checks_done++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, x, g);
		end
	endtask
	task cfg(pin_mode_t m, logic s, logic g);
		for (int p = 0; p < 6; p++) ctrl.mode[p] = m;
		ctrl.secondary_en = s;
		ctrl.secondary_gpio_en = g;
		repeat (3) @(posedge clock);
		#1 e = pin;
		@(posedge clock);
		#1;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task reset_scn;
		check("oe_n", 6'h3F, pad.oe_n);
		check("rx", 6'h00, {srx[1:0], prx});
	endtask
	task tx_scn;
		cfg(PIN_TX, 0, 0);
		check("tx", 6'h34, pad.level);
		check("oe_n", 6'h00, pad.oe_n);
	endtask
	task rx_scn;
		cfg(PIN_RX, 0, 0);
		check("rx", {2'h0, e[3:0]}, {2'h0, prx});
		check("oe_n", 6'h3F, pad.oe_n);
	endtask
	task gpio_scn;
		cfg(PIN_GPIO_OUT, 0, 0);
		check("gout", 6'h15, pad.level);
		cfg(PIN_GPIO_IN, 0, 0);
		check("gin", e, fpi);
		check("gin oe_n", 6'h3F, pad.oe_n);
	endtask
	task sec_scn;
		cfg(PIN_TX, 1, 0);
		check("sec tx", 6'h08, pad.level);
		cfg(PIN_RX, 1, 0);
		check("sec rx", {e[3:2], 2'h0, e[1:0]}, {srx[3:2], prx});
		check("sec rx lo", 6'h00, {4'h0, srx[1:0]});
		cfg(PIN_GPIO_IN, 0, 1);
		check("sec gin", e, {spi, fpi[1:0]});
		check("first gin", 6'h00, {fpi[5:2], 2'h0});
		cfg(PIN_GPIO_OUT, 0, 1);
		check("sec gout", 6'h29, pad.level);
	endtask
	task bad_code_scn;
		cfg(pin_mode_t'(3'h5), 0, 0);
		check("bad oe_n", 6'h3F, pad.oe_n);
		check("bad gin", 6'h00, fpi);
	endtask
	task mid_reset_scn;
		cfg(PIN_TX, 0, 0);
		sys_rst = 1;
		repeat (2) @(posedge clock);
		#1 sys_rst = 0;
		check("rst oe_n", 6'h3F, pad.oe_n);
		@(posedge clock);
		#1;
		check("rst oe_n", 6'h3F, pad.oe_n);
		check("rst lvl", 6'h00, pad.level);
	endtask
	initial begin
		repeat (5) @(posedge clock);
		#1 sys_rst = 0;
		reset_scn();
		tx_scn();
		rx_scn();
		gpio_scn();
		sec_scn();
		bad_code_scn();
		mid_reset_scn();
		give_verdict();
	end
endmodule
